// [rtl/itp_pkg.sv]
// constants and state types shared by both ends of the i2c target port
// assumes one software clock of 250 mhz on the controller side
package itp_pkg;

  // ==========================================================
  // bus address
  localparam logic [7:0] ADDR_BYTE_WRITE = 8'h6c;
  localparam logic [6:0] TARGET_ADDR     = ADDR_BYTE_WRITE[7:1];
  localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
  localparam int         TX_PAIR         = 2;

  // ==========================================================
  // software register map of the target
  localparam logic [1:0] REG_CTRL   = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;
  localparam logic [1:0] REG_DATA   = 2'h2;
  localparam int         CTRL_EN      = 0;
  localparam int         CTRL_EVT_EN  = 1;
  localparam int         ST_RX_READY  = 0;
  localparam int         ST_TX_RESET  = 1;
  localparam int         ST_TX_DONE   = 2;
  localparam int         ST_TX_MODE   = 3;

  // ==========================================================
  // controller timing: scl from ref_clk by a divider
  localparam int         REF_PERIOD_NS    = 4;
  localparam int         SCL_PERIOD_NS    = 160;
  localparam int         QUARTERS_PER_BIT = 4;
  localparam int         MIN_CLK_RATIO    = 2;
  localparam logic [7:0] QUARTER_CYCLES   =
    8'(SCL_PERIOD_NS / (QUARTERS_PER_BIT * REF_PERIOD_NS));
  localparam logic [1:0] PH_DATA   = 2'h0;
  localparam logic [1:0] PH_MID    = 2'h1;
  localparam logic [1:0] PH_HIGH   = 2'h2;
  localparam logic [1:0] PH_SAMPLE = 2'h3;

  // ==========================================================
  // state types
  typedef enum logic [2:0] {
    TS_IDLE, TS_ADDR, TS_ADDR_ACK, TS_RX, TS_RX_ACK,
    TS_TX, TS_TX_ACK, TS_IGNORE
  } itp_tgt_state_t;

  typedef enum logic [1:0] {
    HS_IDLE, HS_START, HS_BIT, HS_STOP
  } itp_host_state_t;

endpackage

// [rtl/itp_bus_if.sv]
// two-wire bus joining the controller and the target
// assumes pull-ups on both wires; drivers only ever pull low
`timescale 1ns/1ps
interface itp_bus_if;

  // ==========================================================
  // drivers and resolved wires
  logic scl;
  logic sda;
  logic host_scl_out;
  logic host_scl_oe;
  logic host_sda_out;
  logic host_sda_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic dev_pullup_en;

  // wired-and of all enabled drivers
  assign scl = !(host_scl_oe && !host_scl_out);
  assign sda = !((host_sda_oe && !host_sda_out) ||
                 (dev_sda_oe && !dev_sda_out));

  modport target (
    input  scl,
    input  sda,
    output dev_sda_out,
    output dev_sda_oe,
    output dev_pullup_en
  );

  modport controller (
    input  scl,
    input  sda,
    output host_scl_out,
    output host_scl_oe,
    output host_sda_out,
    output host_sda_oe
  );

endinterface

// [rtl/itp_target.sv]
// target end of the two-wire port: software registers on ref_clk,
// bus logic on link_clk (the target's own system clock)
// assumes link_clk at least twice the scl rate, scl and sda asynchronous
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/1ps

// Contract
// - target only, one fixed address
// - io zero is scl, io one sda
// - enable bit activates port and pull-ups
// - data line only pulled low
// - after start, seven address bits compared
// - address match acked on ninth clock
// - every written data byte acked
// - full byte sets ready, readable data
// - software clears ready by writing zero
// - keep receiving until stop condition
// - event request per received byte
// - address lsb selects read direction
// - reads served from two-byte buffer
// - software clears reset then loads bytes
// - done set after both bytes sent
// - done event once until reset cleared
// - handler modes also run the port
// - system clock at least twice scl
module itp_target
  import itp_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       link_clk,
  input  wire logic       rst,
  input  wire logic       handler_mode,
  input  wire logic [1:0] sw_addr,
  input  wire logic [7:0] sw_wdata,
  input  wire logic       sw_wr,
  input  wire logic       sw_rd,
  output logic      [7:0] sw_rdata,
  output logic            bus_event_req,
  itp_bus_if.target       bus
);

  // ==========================================================
  // software side (ref_clk)
  logic [1:0] handler_sync;
  logic       bus_port_enable;
  logic       event_en;
  logic       port_active;
  logic       rx_byte_ready;
  logic       tx_buffer_reset;
  logic       tx_pair_done;
  logic [7:0] bus_data_register;
  logic [7:0] tx_buf [TX_PAIR];
  logic       tx_wr_idx;
  logic       tx_wr_tgl;
  logic [2:0] rx_tgl_sync;
  logic [2:0] done_tgl_sync;
  logic [1:0] txmode_sync;
  logic       rx_evt;
  logic       done_evt;
  logic       wr_ctrl;
  logic       wr_status;
  logic       wr_data;

  // link side (link_clk)
  logic [1:0]     lrst_sync;
  logic [1:0]     active_sync;
  logic [2:0]     scl_sync;
  logic [2:0]     sda_sync;
  logic [2:0]     txw_sync;
  logic [7:0]     link_buf [TX_PAIR];
  itp_tgt_state_t state;
  logic [3:0]     bit_cnt;
  logic [7:0]     shift;
  logic           read_dir;
  logic           sent_idx;
  logic           sda_low;
  logic [7:0]     rx_hold;
  logic           rx_tgl;
  logic           done_tgl;
  logic           tx_mode;
  logic           link_rst;
  logic           scl_rise;
  logic           scl_fall;
  logic           start_seen;
  logic           stop_seen;

  // event edges from the link, taken from second and third stages
  assign rx_evt   = rx_tgl_sync[2] ^ rx_tgl_sync[1];
  assign done_evt = done_tgl_sync[2] ^ done_tgl_sync[1];
  assign wr_ctrl   = sw_wr && (sw_addr == REG_CTRL);
  assign wr_status = sw_wr && (sw_addr == REG_STATUS);
  assign wr_data   = sw_wr && (sw_addr == REG_DATA);

  // synchronisers into ref_clk
  always_ff @(posedge ref_clk) begin
    handler_sync  <= {handler_sync[0], handler_mode};
    rx_tgl_sync   <= {rx_tgl_sync[1:0], rx_tgl};
    done_tgl_sync <= {done_tgl_sync[1:0], done_tgl};
    txmode_sync   <= {txmode_sync[0], tx_mode};
  end

  // control register and port activation
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bus_port_enable <= 1'b0;
      event_en        <= 1'b0;
      port_active     <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        bus_port_enable <= sw_wdata[CTRL_EN];
        event_en        <= sw_wdata[CTRL_EVT_EN];
      end
      port_active <= bus_port_enable || handler_sync[1];
    end
  end

  // status flags: a hardware set wins over a software clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rx_byte_ready   <= 1'b0;
      tx_buffer_reset <= 1'b1;
      tx_pair_done    <= 1'b0;
    end else begin
      if (rx_evt)
        rx_byte_ready <= 1'b1;
      else if (wr_status && !sw_wdata[ST_RX_READY])
        rx_byte_ready <= 1'b0;
      if (done_evt && !tx_buffer_reset) begin
        tx_pair_done    <= 1'b1;
        tx_buffer_reset <= 1'b1;
      end else begin
        if (wr_status && !sw_wdata[ST_TX_RESET])
          tx_buffer_reset <= 1'b0;
        if (wr_status && !sw_wdata[ST_TX_DONE])
          tx_pair_done <= 1'b0;
      end
    end
  end

  // received byte and event request
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bus_data_register <= 8'h00;
      bus_event_req     <= 1'b0;
    end else begin
      if (rx_evt)
        bus_data_register <= rx_hold;
      bus_event_req <= event_en &&
                       (rx_evt || (done_evt && !tx_buffer_reset));
    end
  end

  // transmit buffer writes, announced by a toggle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_buf[0] <= 8'hff;
      tx_buf[1] <= 8'hff;
      tx_wr_idx <= 1'b0;
      tx_wr_tgl <= 1'b0;
    end else if (wr_status && !sw_wdata[ST_TX_RESET]) begin
      tx_wr_idx <= 1'b0;
    end else if (wr_data) begin
      tx_buf[tx_wr_idx] <= sw_wdata;
      tx_wr_idx         <= !tx_wr_idx;
      tx_wr_tgl         <= !tx_wr_tgl;
    end
  end

  // read data: valid only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (rst || !sw_rd)
      sw_rdata <= 8'h00;
    else if (sw_addr == REG_CTRL)
      sw_rdata <= {6'h00, event_en, bus_port_enable};
    else if (sw_addr == REG_STATUS)
      sw_rdata <= {4'h0, txmode_sync[1], tx_pair_done,
                   tx_buffer_reset, rx_byte_ready};
    else if (sw_addr == REG_DATA)
      sw_rdata <= bus_data_register;
    else
      sw_rdata <= 8'h00;
  end

  // ==========================================================
  // link side synchronisers
  // pins sampled by link_clk
  always_ff @(posedge link_clk) begin
    lrst_sync   <= {lrst_sync[0], rst};
    active_sync <= {active_sync[0], port_active};
    scl_sync    <= {scl_sync[1:0], bus.scl};
    sda_sync    <= {sda_sync[1:0], bus.sda};
    txw_sync    <= {txw_sync[1:0], tx_wr_tgl};
  end

  assign link_rst   = lrst_sync[1];
  assign scl_rise   = scl_sync[1] && !scl_sync[2];
  assign scl_fall   = !scl_sync[1] && scl_sync[2];
  assign start_seen = scl_sync[1] && scl_sync[2] &&
                      !sda_sync[1] && sda_sync[2];
  assign stop_seen  = scl_sync[1] && scl_sync[2] &&
                      sda_sync[1] && !sda_sync[2];

  // local copy of the message, refreshed on each buffer write
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      link_buf[0] <= 8'hff;
      link_buf[1] <= 8'hff;
    end else if (txw_sync[2] ^ txw_sync[1]) begin
      link_buf[0] <= tx_buf[0];
      link_buf[1] <= tx_buf[1];
    end
  end

  // byte engine
  always_ff @(posedge link_clk) begin
    if (link_rst || !active_sync[1]) begin
      state    <= TS_IDLE;
      bit_cnt  <= 4'h0;
      shift    <= 8'h00;
      read_dir <= 1'b0;
      sent_idx <= 1'b0;
      sda_low  <= 1'b0;
      rx_hold  <= 8'h00;
      rx_tgl   <= 1'b0;
      done_tgl <= 1'b0;
      tx_mode  <= 1'b0;
    end else if (start_seen) begin
      state    <= TS_ADDR;
      bit_cnt  <= 4'h0;
      sent_idx <= 1'b0;
      sda_low  <= 1'b0;
      tx_mode  <= 1'b0;
    end else if (stop_seen) begin
      state   <= TS_IDLE;
      sda_low <= 1'b0;
      tx_mode <= 1'b0;
    end else begin
      case (state)
        TS_ADDR, TS_RX: begin
          if (scl_rise) begin
            shift   <= {shift[6:0], sda_sync[1]};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == BITS_PER_BYTE) begin
            bit_cnt <= 4'h0;
            if (state == TS_ADDR) begin
              if (shift[7:1] == TARGET_ADDR) begin
                sda_low  <= 1'b1;
                read_dir <= shift[0];
                state    <= TS_ADDR_ACK;
              end else begin
                state <= TS_IGNORE;
              end
            end else begin
              sda_low <= 1'b1;
              rx_hold <= shift;
              rx_tgl  <= !rx_tgl;
              state   <= TS_RX_ACK;
            end
          end
        end
        TS_ADDR_ACK: begin
          if (scl_fall) begin
            if (read_dir) begin
              shift   <= link_buf[0];
              sda_low <= !link_buf[0][7];
              tx_mode <= 1'b1;
              state   <= TS_TX;
            end else begin
              sda_low <= 1'b0;
              state   <= TS_RX;
            end
          end
        end
        TS_RX_ACK: begin
          if (scl_fall) begin
            sda_low <= 1'b0;
            state   <= TS_RX;
          end
        end
        TS_TX: begin
          if (scl_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt == BITS_PER_BYTE) begin
              sda_low <= 1'b0;
              bit_cnt <= 4'h0;
              state   <= TS_TX_ACK;
            end else begin
              shift   <= {shift[6:0], 1'b0};
              sda_low <= !shift[6];
            end
          end
        end
        TS_TX_ACK: begin
          if (scl_rise) begin
            sent_idx <= 1'b1;
            if (sent_idx)
              done_tgl <= !done_tgl;
            if (sda_sync[1])
              state <= TS_IGNORE;
          end else if (scl_fall) begin
            shift   <= link_buf[sent_idx];
            sda_low <= !link_buf[sent_idx][7];
            state   <= TS_TX;
          end
        end
        default: begin
          sda_low <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // pin drivers
  // open-drain data line
  assign bus.dev_sda_out   = 1'b0;
  assign bus.dev_sda_oe    = sda_low;
  assign bus.dev_pullup_en = port_active;

endmodule

// [rtl/itp_controller.sv]
// controller end of the two-wire bus: runs whole transfers on command
// assumes the target samples at least twice as fast as scl
`timescale 1ns/1ps
module itp_controller
  import itp_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       cmd_go,
  input  wire logic [6:0] cmd_addr,
  input  wire logic       cmd_read,
  input  wire logic [3:0] cmd_len,
  input  wire logic [7:0] wr_data,
  output logic            wr_take,
  output logic      [7:0] rd_data,
  output logic            rd_valid,
  output logic            busy,
  output logic            nacked,
  itp_bus_if.controller   bus
);

  // ==========================================================
  // state
  itp_host_state_t state;
  logic [7:0]      qcnt;
  logic [1:0]      phase;
  logic [3:0]      bit_cnt;
  logic [3:0]      byte_cnt;
  logic [7:0]      shift;
  logic            is_addr;
  logic            rd;
  logic            scl_low;
  logic            sda_low;
  logic [1:0]      sda_sync;
  logic            tick;
  logic            we_drive;

  assign tick     = (qcnt == QUARTER_CYCLES - 8'h01);
  assign we_drive = is_addr || !rd;

  // data line synchroniser
  always_ff @(posedge ref_clk) begin
    sda_sync <= {sda_sync[0], bus.sda};
  end

  // quarter-bit divider and phase
  always_ff @(posedge ref_clk) begin
    if (rst || state == HS_IDLE) begin
      qcnt  <= 8'h00;
      phase <= PH_DATA;
    end else if (tick) begin
      qcnt  <= 8'h00;
      phase <= phase + 2'h1;
    end else begin
      qcnt <= qcnt + 8'h01;
    end
  end

  // transfer sequencer
  always_ff @(posedge ref_clk) begin
    wr_take  <= 1'b0;
    rd_valid <= 1'b0;
    if (rst) begin
      state    <= HS_IDLE;
      bit_cnt  <= 4'h0;
      byte_cnt <= 4'h0;
      shift    <= 8'h00;
      is_addr  <= 1'b0;
      rd       <= 1'b0;
      scl_low  <= 1'b0;
      sda_low  <= 1'b0;
      rd_data  <= 8'h00;
      busy     <= 1'b0;
      nacked   <= 1'b0;
    end else begin
      case (state)
        HS_IDLE: begin
          if (cmd_go) begin
            shift    <= {cmd_addr, cmd_read};
            rd       <= cmd_read;
            byte_cnt <= cmd_len;
            is_addr  <= 1'b1;
            bit_cnt  <= 4'h0;
            busy     <= 1'b1;
            nacked   <= 1'b0;
            state    <= HS_START;
          end
        end
        HS_START: begin
          if (tick && phase == PH_HIGH)
            sda_low <= 1'b1;
          else if (tick && phase == PH_SAMPLE) begin
            scl_low <= 1'b1;
            state   <= HS_BIT;
          end
        end
        HS_BIT: begin
          if (tick && phase == PH_DATA) begin
            scl_low <= 1'b1;
            if (bit_cnt != BITS_PER_BYTE)
              sda_low <= we_drive && !shift[7];
            else
              sda_low <= !we_drive && (byte_cnt != 4'h1);
          end else if (tick && phase == PH_HIGH) begin
            scl_low <= 1'b0;
          end else if (tick && phase == PH_SAMPLE) begin
            if (bit_cnt != BITS_PER_BYTE) begin
              shift   <= {shift[6:0], sda_sync[1]};
              bit_cnt <= bit_cnt + 4'h1;
            end else begin
              bit_cnt <= 4'h0;
              is_addr <= 1'b0;
              if (we_drive && sda_sync[1]) begin
                nacked <= 1'b1;
                state  <= HS_STOP;
              end else if (rd && !is_addr) begin
                rd_data  <= shift;
                rd_valid <= 1'b1;
                byte_cnt <= byte_cnt - 4'h1;
                if (byte_cnt == 4'h1)
                  state <= HS_STOP;
              end else if (byte_cnt == 4'h0) begin
                state <= HS_STOP;
              end else if (!rd) begin
                shift    <= wr_data;
                wr_take  <= 1'b1;
                byte_cnt <= byte_cnt - 4'h1;
              end
            end
          end
        end
        HS_STOP: begin
          if (tick && phase == PH_DATA) begin
            scl_low <= 1'b1;
            sda_low <= 1'b1;
          end else if (tick && phase == PH_MID) begin
            scl_low <= 1'b0;
          end else if (tick && phase == PH_HIGH) begin
            sda_low <= 1'b0;
          end else if (tick && phase == PH_SAMPLE) begin
            busy  <= 1'b0;
            state <= HS_IDLE;
          end
        end
        default: begin
          state <= HS_IDLE;
        end
      endcase
    end
  end

  // open-drain drivers
  assign bus.host_scl_out = 1'b0;
  assign bus.host_scl_oe  = scl_low;
  assign bus.host_sda_out = 1'b0;
  assign bus.host_sda_oe  = sda_low;

endmodule

// [tb/itp_bus_sva.sv]
// checker on the two-wire bus between controller and target ends
// assumes scl and sda only move well clear of ref_clk edges
`timescale 1ns/1ps
module itp_bus_sva
  import itp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic link_clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_out,
  input wire logic dev_sda_oe,
  input wire logic dev_pullup_en
);
  logic       scl_q;
  logic       sda_q;
  logic [3:0] bitn;
  logic [7:0] shreg;
  logic       first;
  logic       sel;
  logic       rd;
  logic       start;
  logic       stop;
  logic       rise;
  // link-side settle window: the target's link logic resets a few
  // link_clk edges after rst, so pin checks wait for it
  logic [3:0] lrst_q = 4'hf;

  always @(posedge link_clk) begin
    lrst_q <= {lrst_q[2:0], rst};
  end

  // ==========================================================
  // bus framing seen from ref_clk
  assign start = scl && scl_q && sda_q && !sda;
  assign stop  = scl && scl_q && !sda_q && sda;
  assign rise  = scl && !scl_q;

  // bit count, address capture and direction per frame
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      bitn  <= 4'h0;
      shreg <= 8'h00;
      first <= 1'b0;
      sel   <= 1'b0;
      rd    <= 1'b0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start) begin
        bitn  <= 4'h0;
        first <= 1'b1;
        sel   <= 1'b0;
      end else if (rise) begin
        bitn <= (bitn == 4'h8) ? 4'h0 : bitn + 4'h1;
        if (bitn != 4'h8) shreg <= {shreg[6:0], sda};
        if (bitn == 4'h8 && first) begin
          first <= 1'b0;
          sel   <= (shreg[7:1] == TARGET_ADDR);
          rd    <= shreg[0];
        end
      end
    end
  end

  // ==========================================================
  // assertions
  sequence ninth_rise;
    rise && bitn == 4'h8;
  endsequence

  sequence addr_hit;
    first && shreg[7:1] == TARGET_ADDR && dev_pullup_en;
  endsequence

  a_addr_ack: assert property (@(posedge ref_clk) disable iff (rst)
    ninth_rise ##0 addr_hit |-> dev_sda_oe && !sda)
    else $error("address byte not acknowledged");
  a_addr_miss: assert property (@(posedge ref_clk) disable iff (rst)
    ninth_rise ##0 (first && shreg[7:1] != TARGET_ADDR) |-> !dev_sda_oe)
    else $error("foreign address acknowledged");
  a_write_ack: assert property (@(posedge ref_clk) disable iff (rst)
    ninth_rise ##0 (!first && sel && !rd && dev_pullup_en) |-> dev_sda_oe)
    else $error("written byte not acknowledged");
  a_read_release: assert property (@(posedge ref_clk) disable iff (rst)
    ninth_rise ##0 (!first && sel && rd) |-> !dev_sda_oe)
    else $error("target holds sda on read ack bit");
  a_stop_quiet: assert property (@(posedge ref_clk) disable iff (rst)
    stop |=> !dev_sda_oe [*8])
    else $error("target drives sda after stop");
  a_off_quiet: assert property (@(posedge ref_clk)
    disable iff (rst || lrst_q[3])
    !dev_pullup_en |-> !dev_sda_oe)
    else $error("inactive port drives sda");
  a_pull_low: assert property (@(posedge link_clk)
    disable iff (rst || lrst_q[3])
    dev_sda_oe |-> dev_sda_out == 1'b0)
    else $error("target drives sda high");
  a_high_stable: assert property (@(posedge link_clk)
    disable iff (rst || lrst_q[3])
    scl && $past(scl) |-> $stable(dev_sda_oe))
    else $error("target moves sda while scl high");
endmodule

// [tb/tb.sv]
// top bench: controller end and target end joined by the bus
// assumes both ends reset together from rst on ref_clk
`timescale 1ns/1ps
module tb;
  import itp_pkg::*;
  logic       ref_clk, link_clk, rst, handler_mode;
  logic [1:0] sw_addr;
  logic [7:0] sw_wdata, sw_rdata, wr_data, rd_data;
  logic       sw_wr, sw_rd, bus_event_req, cmd_go, cmd_read;
  logic [6:0] cmd_addr;
  logic [3:0] cmd_len;
  logic       wr_take, rd_valid, busy, nacked;
  logic [7:0] wbuf [4];
  logic [7:0] rdq [$];
  int         widx, ev_cnt, failures, n_checks;

  itp_bus_if bus_if ();
  itp_target i_itp_target (.ref_clk(ref_clk), .link_clk(link_clk),
    .rst(rst), .handler_mode(handler_mode), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
    .sw_rdata(sw_rdata), .bus_event_req(bus_event_req), .bus(bus_if));
  itp_controller i_itp_controller (.ref_clk(ref_clk), .rst(rst),
    .cmd_go(cmd_go), .cmd_addr(cmd_addr), .cmd_read(cmd_read),
    .cmd_len(cmd_len), .wr_data(wr_data), .wr_take(wr_take),
    .rd_data(rd_data), .rd_valid(rd_valid), .busy(busy),
    .nacked(nacked), .bus(bus_if));
  itp_bus_sva i_itp_bus_sva (.ref_clk(ref_clk), .link_clk(link_clk),
    .rst(rst), .scl(bus_if.scl), .sda(bus_if.sda),
    .dev_sda_out(bus_if.dev_sda_out), .dev_sda_oe(bus_if.dev_sda_oe),
    .dev_pullup_en(bus_if.dev_pullup_en));

  // ==========================================================
  // clocks, write byte feed, event and read capture
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    link_clk = 1'b0;
    #1.3;
    forever #3 link_clk = ~link_clk;
  end
  assign wr_data = wbuf[widx[1:0]];
  always @(posedge ref_clk) begin
    if (wr_take === 1'b1) widx <= widx + 1;
    if (bus_event_req === 1'b1) ev_cnt <= ev_cnt + 1;
    if (rd_valid === 1'b1) rdq.push_back(rd_data);
  end

  // ==========================================================
  // shared tasks
  task automatic chk(input string name, input logic [7:0] exp,
                     input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic sw_write(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sw_addr  <= a;
    sw_wdata <= d;
    sw_wr    <= 1'b1;
    @(posedge ref_clk);
    sw_wr <= 1'b0;
  endtask
  task automatic sw_check(input logic [1:0] a, input logic [7:0] exp,
                          input string name);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_rd   <= 1'b1;
    @(posedge ref_clk);
    sw_rd <= 1'b0;
    #1 chk(name, exp, sw_rdata);
  endtask
  task automatic xfer(input logic [6:0] a, input logic r,
                      input logic [3:0] n);
    rdq.delete();
    ev_cnt = 0;
    widx = 0;
    @(posedge ref_clk);
    cmd_addr <= a;
    cmd_read <= r;
    cmd_len  <= n;
    cmd_go   <= 1'b1;
    @(posedge ref_clk);
    cmd_go <= 1'b0;
    for (int i = 0; i < 4000; i++) begin
      @(posedge ref_clk);
      #1;
      if (busy !== 1'b1) break;
    end
    // a transfer that never ends counts as a mismatch
    chk("busy_end", 8'h00, {7'h0, busy});
    repeat (12) @(posedge ref_clk);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset;
    sw_check(REG_STATUS, 8'h02, "status_rst");
    sw_check(REG_CTRL, 8'h00, "ctrl_rst");
    sw_check(2'h3, 8'h00, "unmapped");
  endtask
  task automatic t_mismatch;
    sw_write(REG_CTRL, 8'h03);
    wbuf[0] = 8'h11;
    xfer(7'h35, 1'b0, 4'h1);
    chk("nack_foreign", 8'h01, {7'h0, nacked});
    chk("ev_foreign", 8'h00, 8'(ev_cnt));
  endtask
  task automatic t_write;
    wbuf[0] = 8'ha5;
    wbuf[1] = 8'h3c;
    xfer(TARGET_ADDR, 1'b0, 4'h2);
    chk("nack_write", 8'h00, {7'h0, nacked});
    chk("ev_write", 8'h02, 8'(ev_cnt));
    sw_check(REG_STATUS, 8'h03, "status_rx");
    sw_check(REG_DATA, 8'h3c, "data_last");
    sw_write(REG_STATUS, 8'h06);
    sw_check(REG_STATUS, 8'h02, "status_clr");
  endtask
  task automatic t_read;
    logic [7:0] exp [3];
    exp = '{8'h5a, 8'hc3, 8'hc3};
    sw_write(REG_STATUS, 8'h05);
    sw_check(REG_STATUS, 8'h00, "status_arm");
    sw_write(REG_DATA, 8'h5a);
    sw_write(REG_DATA, 8'hc3);
    xfer(TARGET_ADDR, 1'b1, 4'h1);
    chk("rd_short", 8'h5a, rdq[0]);
    chk("ev_short", 8'h00, 8'(ev_cnt));
    sw_check(REG_STATUS, 8'h00, "status_short");
    xfer(TARGET_ADDR, 1'b1, 4'h3);
    chk("rd_count", 8'h03, 8'(rdq.size()));
    for (int i = 0; i < 3; i++) chk("rd_byte", exp[i], rdq[i]);
    chk("ev_done", 8'h01, 8'(ev_cnt));
    sw_check(REG_STATUS, 8'h06, "status_done");
    xfer(TARGET_ADDR, 1'b1, 4'h2);
    chk("ev_again", 8'h00, 8'(ev_cnt));
  endtask
  task automatic t_disabled;
    sw_write(REG_CTRL, 8'h00);
    wbuf[0] = 8'h77;
    xfer(TARGET_ADDR, 1'b0, 4'h1);
    chk("nack_off", 8'h01, {7'h0, nacked});
    @(posedge ref_clk);
    handler_mode <= 1'b1;
    repeat (4) @(posedge ref_clk);
    xfer(TARGET_ADDR, 1'b0, 4'h1);
    chk("nack_handler", 8'h00, {7'h0, nacked});
    chk("ev_masked", 8'h00, 8'(ev_cnt));
    sw_check(REG_DATA, 8'h77, "data_handler");
  endtask

  // ==========================================================
  // verdict and run control
  task automatic conclude;
    if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #300000;
    failures++;
    conclude();
  end
  initial begin
    rst = 1'b1;
    handler_mode = 1'b0;
    sw_addr = 2'h0;
    sw_wdata = 8'h00;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    cmd_go = 1'b0;
    cmd_addr = 7'h00;
    cmd_read = 1'b0;
    cmd_len = 4'h1;
    wbuf = '{8'h00, 8'h00, 8'h00, 8'h00};
    widx = 0;
    ev_cnt = 0;
    failures = 0;
    n_checks = 0;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    t_reset();
    t_mismatch();
    t_write();
    t_read();
    t_disabled();
    conclude();
  end
endmodule
